/* File: core/ivm_pkg.sv */
// Constants, register map and state types for the upper interrupt vector map.
// Assumes a single 100 MHz clock domain and a classic Wishbone register port.
//
// Function
// R1: First UART fault/receive/transmit are requests 39-41, vector 32, slot 0 of group a.
// R2: First two-wire collision/slave/master are requests 42-44, vector 33, slot 1.
// R3: Port A/B/C input change are requests 45-47, vector 34, slot 2.
// R4: Parallel port event and error are requests 48-49, vector 35, slot 3.
// R5: Second SPI fault/receive/transfer are requests 50-52, vector 36, group b slot 0.
// R6: Second UART error/receiver/transmitter are requests 53-55, vector 37, group b slot 1.
// R7: Second two-wire collision/slave/master are requests 56-58, vector 38, group b slot 2.
// R8: Four transfer channels are requests 60-63, own vectors 40-43, group c lanes.
// R9: Requests 39 to 59 are persistent; the four transfer channels are not.
// R10: Equal priority and sub-priority ties resolve by natural order; request 63 ranks lowest.
// R11: Parallel port event raises vector 35 through flag and enable bit 16.
// R12: A persistent flag sets again after clearing while its source stays active.
// R13: Software reads individual flags under a shared vector and clears only handled ones.

package ivm_pkg;

   // ----------------------------------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------------------------------
   localparam logic [7:0] ADR_FLAG = 8'h00;
   localparam logic [7:0] ADR_ENABLE = 8'h04;
   localparam logic [7:0] ADR_PRIO_A = 8'h08;
   localparam logic [7:0] ADR_PRIO_B = 8'h0c;
   localparam logic [7:0] ADR_PRIO_C = 8'h10;
   localparam logic [31:0] REG_RESET = 32'h0000_0000;
   localparam logic [31:0] FLAG_MASK = 32'hffff_ff80;
   localparam logic [31:0] PRIO_MASK = 32'h1f1f_1f1f;

   // ----------------------------------------------------------------
   // Source layout
   // ----------------------------------------------------------------
   localparam int NUM_SRC = 25;
   localparam int FLAG_LSB = 7;
   localparam int LANE_W = 8;
   localparam int PRIO_LSB = 2;
   localparam int PRIO_W = 3;
   localparam int SUB_W = 2;
   localparam logic [5:0] FIRST_IRQ = 6'h27;
   localparam logic [5:0] VEC_BASE = 6'h20;
   // Priority slot of each source, source 0 is request 39
   localparam logic [24:0][3:0] SRC_SLOT = {
      4'hb, 4'ha, 4'h9, 4'h8, 4'h7,
      4'h6, 4'h6, 4'h6, 4'h5, 4'h5, 4'h5, 4'h4, 4'h4, 4'h4,
      4'h3, 4'h3, 4'h2, 4'h2, 4'h2, 4'h1, 4'h1, 4'h1, 4'h0, 4'h0, 4'h0};
   localparam logic [24:0] SRC_PERSIST = 25'h01f_ffff;

   // ----------------------------------------------------------------
   // State types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic flag;
      logic prev;
   } ivm_cell_s;

   typedef struct packed {
      logic [31:0] en;
      logic [31:0] pa;
      logic [31:0] pb;
      logic [31:0] pc;
      logic ack;
      logic [31:0] rdat;
      logic irq;
      logic vreq;
      logic [5:0] virq;
      logic [5:0] vnum;
      logic [2:0] vprio;
      logic [1:0] vsub;
   } ivm_state_s;

endpackage : ivm_pkg

/* File: core/ivm_flag_cell.sv */
// One interrupt flag: set by its source, cleared by a one written from software.
// Assumes the clear strobe is a single-cycle pulse from the register port.
`timescale 1ns/1ns
`default_nettype none

module ivm_flag_cell #(
   parameter bit PERSIST = 1'b1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Source and software clear
   input wire logic evt,
   input wire logic clr,
   // Flag state
   output logic flag
);

   ivm_pkg::ivm_cell_s q;
   ivm_pkg::ivm_cell_s d;
   logic set;

   always_comb begin
      d = q;
      // Persistent sources are levels; others latch only a rising edge
      set = PERSIST ? evt : (evt & ~q.prev); // see R9
      // Set wins over a clear in the same cycle, so an active level returns
      d.flag = set | (q.flag & ~clr); // see R12
      d.prev = evt;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign flag = q.flag;

endmodule : ivm_flag_cell
`default_nettype wire

/* File: core/ivm_arbiter.sv */
// Picks the winning pending source by priority, sub-priority, then natural order.
// Purely combinational; the caller registers its result.
`timescale 1ns/1ns
`default_nettype none

module ivm_arbiter (
   // Pending sources and the three priority registers
   input wire logic [24:0] pending,
   input wire logic [95:0] prio_all,
   // Winner
   output logic found,
   output logic [4:0] idx,
   output logic [2:0] prio,
   output logic [1:0] sub
);

   always_comb begin
      int base;
      logic [2:0] p;
      logic [1:0] s;
      base = 0;
      p = '0;
      s = '0;
      found = 1'b0;
      idx = '0;
      prio = '0;
      sub = '0;
      for (int i = 0; i < ivm_pkg::NUM_SRC; i++) begin
         base = int'(ivm_pkg::SRC_SLOT[i]) * ivm_pkg::LANE_W;
         p = prio_all[base + ivm_pkg::PRIO_LSB +: ivm_pkg::PRIO_W];
         s = prio_all[base +: ivm_pkg::SUB_W];
         // Priority zero keeps a source off; strict compare keeps the lower request
         if (pending[i] && (p != 3'h0) && (!found || {p, s} > {prio, sub})) begin // see R10
            found = 1'b1;
            idx = 5'(i);
            prio = p;
            sub = s;
         end
      end
   end

endmodule : ivm_arbiter
`default_nettype wire

/* File: core/ivm_irq_vector_map_upper.sv */
// Upper interrupt source map: flags, enables, priorities and vector request.
// Assumes a classic Wishbone master and source lines synchronous to clk.
//
// Implementation choices: register access over Wishbone and the placing of the registers.
`timescale 1ns/1ns
`default_nettype none

module ivm_irq_vector_map_upper (
   // Clock and reset
   input wire logic clk,
   input wire logic reset_n,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // First UART
   input wire logic uart_one_fault,
   input wire logic uart_one_receive_done,
   input wire logic uart_one_transmit_done,
   // First two-wire unit
   input wire logic twi_one_collision,
   input wire logic twi_one_slave_event,
   input wire logic twi_one_master_event,
   // Input change
   input wire logic port_a_input_change,
   input wire logic port_b_input_change,
   input wire logic port_c_input_change,
   // Parallel port
   input wire logic parallel_port_event,
   input wire logic parallel_port_error,
   // Second SPI
   input wire logic spi_two_fault,
   input wire logic spi_two_receive_done,
   input wire logic spi_two_transfer_done,
   // Second UART
   input wire logic uart_two_error,
   input wire logic uart_two_receiver,
   input wire logic uart_two_transmitter,
   // Second two-wire unit
   input wire logic twi_two_collision,
   input wire logic twi_two_slave_event,
   input wire logic twi_two_master_event,
   // Charge measurement unit
   input wire logic charge_meas_event,
   // Transfer channels
   input wire logic xfer_channel_zero,
   input wire logic xfer_channel_one,
   input wire logic xfer_channel_two,
   input wire logic xfer_channel_three,
   // Towards the core
   output logic irq_o,
   output logic vec_req_o,
   output logic [5:0] vec_irq_o,
   output logic [5:0] vec_num_o,
   output logic [2:0] vec_prio_o,
   output logic [1:0] vec_sub_o
);

   ivm_pkg::ivm_state_s q;
   ivm_pkg::ivm_state_s d;
   logic [24:0] src_evt;
   logic [24:0] flags;
   logic [24:0] clr;
   logic [31:0] bmask;
   logic bus_req;
   logic bus_wr;
   logic [31:0] flag_reg;
   logic arb_found;
   logic [4:0] arb_idx;
   logic [2:0] arb_prio;
   logic [1:0] arb_sub;

   // ----------------------------------------------------------------
   // Source lines in request order, 39 at bit 0
   // ----------------------------------------------------------------
   assign src_evt = {
      xfer_channel_three, xfer_channel_two, xfer_channel_one, xfer_channel_zero, // see R8
      charge_meas_event,
      twi_two_master_event, twi_two_slave_event, twi_two_collision, // see R7
      uart_two_transmitter, uart_two_receiver, uart_two_error, // see R6
      spi_two_transfer_done, spi_two_receive_done, spi_two_fault, // see R5
      parallel_port_error, parallel_port_event, // see R4
      port_c_input_change, port_b_input_change, port_a_input_change, // see R3
      twi_one_master_event, twi_one_slave_event, twi_one_collision, // see R2
      uart_one_transmit_done, uart_one_receive_done, uart_one_fault}; // see R1

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   assign bus_req = wb_cyc_i & wb_stb_i & ~q.ack;
   assign bus_wr = bus_req & wb_we_i;
   assign flag_reg = {flags, {ivm_pkg::FLAG_LSB{1'b0}}};

   always_comb begin
      for (int b = 0; b < 4; b++) begin
         bmask[b*8 +: 8] = {8{wb_sel_i[b]}};
      end
   end

   // Writing a one clears a flag; other flags are left untouched
   assign clr = (bus_wr && wb_adr_i == ivm_pkg::ADR_FLAG)
              ? wb_dat_i[31:ivm_pkg::FLAG_LSB] & bmask[31:ivm_pkg::FLAG_LSB]
              : '0;

   // ----------------------------------------------------------------
   // Flags
   // ----------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < ivm_pkg::NUM_SRC; gi++) begin : g_flag
         ivm_flag_cell #(
            .PERSIST(ivm_pkg::SRC_PERSIST[gi]) // see R9
         ) u_cell (
            .clk(clk),
            .reset_n(reset_n),
            .evt(src_evt[gi]),
            .clr(clr[gi]),
            .flag(flags[gi])
         );
      end
   endgenerate

   // ----------------------------------------------------------------
   // Arbitration
   // ----------------------------------------------------------------
   ivm_arbiter u_arb (
      .pending(flags & q.en[31:ivm_pkg::FLAG_LSB]),
      .prio_all({q.pc, q.pb, q.pa}),
      .found(arb_found),
      .idx(arb_idx),
      .prio(arb_prio),
      .sub(arb_sub)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      d = q;
      d.ack = bus_req;
      d.rdat = '0;
      if (bus_req && !wb_we_i) begin
         case (wb_adr_i)
            ivm_pkg::ADR_FLAG: d.rdat = flag_reg;
            ivm_pkg::ADR_ENABLE: d.rdat = q.en;
            ivm_pkg::ADR_PRIO_A: d.rdat = q.pa;
            ivm_pkg::ADR_PRIO_B: d.rdat = q.pb;
            ivm_pkg::ADR_PRIO_C: d.rdat = q.pc;
            default: d.rdat = '0;
         endcase
      end
      if (bus_wr) begin
         case (wb_adr_i)
            ivm_pkg::ADR_ENABLE: begin
               d.en = ((q.en & ~bmask) | (wb_dat_i & bmask)) & ivm_pkg::FLAG_MASK;
            end
            ivm_pkg::ADR_PRIO_A: begin
               d.pa = ((q.pa & ~bmask) | (wb_dat_i & bmask)) & ivm_pkg::PRIO_MASK;
            end
            ivm_pkg::ADR_PRIO_B: begin
               d.pb = ((q.pb & ~bmask) | (wb_dat_i & bmask)) & ivm_pkg::PRIO_MASK;
            end
            ivm_pkg::ADR_PRIO_C: begin
               d.pc = ((q.pc & ~bmask) | (wb_dat_i & bmask)) & ivm_pkg::PRIO_MASK;
            end
            default: d.en = q.en;
         endcase
      end
      // Level output follows any enabled flag, priority aside
      d.irq = |(flags & q.en[31:ivm_pkg::FLAG_LSB]);
      d.vreq = arb_found;
      d.virq = arb_found ? ivm_pkg::FIRST_IRQ + 6'(arb_idx) : 6'h00;
      // Shared vectors: software tells the sources apart by reading flags
      d.vnum = arb_found ? ivm_pkg::VEC_BASE + 6'(ivm_pkg::SRC_SLOT[arb_idx]) : 6'h00; // see R11
      d.vprio = arb_found ? arb_prio : 3'h0;
      d.vsub = arb_found ? arb_sub : 2'h0;
   end

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign wb_ack_o = q.ack;
   assign wb_dat_o = q.rdat;
   assign irq_o = q.irq;
   assign vec_req_o = q.vreq;
   assign vec_irq_o = q.virq;
   assign vec_num_o = q.vnum;
   assign vec_prio_o = q.vprio;
   assign vec_sub_o = q.vsub;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence wb_req_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence

   sequence wr_uart_clr_s;
      wb_req_s and (wb_we_i && wb_adr_i == ivm_pkg::ADR_FLAG && wb_sel_i[0] && wb_dat_i[7]);
   endsequence

   sequence wr_en_s;
      wb_req_s and (wb_we_i && wb_adr_i == ivm_pkg::ADR_ENABLE && wb_sel_i == 4'hf);
   endsequence

   sequence wr_xfer_clr_s;
      wb_req_s and (wb_we_i && wb_adr_i == ivm_pkg::ADR_FLAG && wb_sel_i[3] && wb_dat_i[31]);
   endsequence

   bus_ack_timing_a: assert property (@(posedge clk) disable iff (!reset_n)
      wb_req_s |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not given once, one cycle after request");

   uart_one_vec_a: assert property (@(posedge clk) disable iff (!reset_n) // see R1
      (vec_req_o && vec_irq_o == 6'h28) |-> vec_num_o == 6'h20)
      else $error("request 40 did not map to vector 32");

   twi_one_vec_a: assert property (@(posedge clk) disable iff (!reset_n) // see R2
      (vec_req_o && vec_irq_o == 6'h2b) |-> vec_num_o == 6'h21)
      else $error("request 43 did not map to vector 33");

   pmp_vec_a: assert property (@(posedge clk) disable iff (!reset_n) // see R11
      (vec_req_o && vec_irq_o == 6'h30)
         |-> (vec_num_o == 6'h23 && $past(q.en[16]) && $past(flags[9])))
      else $error("request 48 did not map to vector 35 via bit 16");

   spi_two_vec_a: assert property (@(posedge clk) disable iff (!reset_n) // see R5
      (vec_req_o && vec_irq_o == 6'h33) |-> vec_num_o == 6'h24)
      else $error("request 51 did not map to vector 36");

   xfer_vec_a: assert property (@(posedge clk) disable iff (!reset_n) // see R8
      (vec_req_o && vec_irq_o == 6'h3f) |-> vec_num_o == 6'h2b)
      else $error("request 63 did not map to vector 43");

   persist_reset_a: assert property (@(posedge clk) disable iff (!reset_n) // see R12
      (wr_uart_clr_s and uart_one_fault) |=> flags[0])
      else $error("persistent flag did not set again while source active");

   xfer_edge_only_a: assert property (@(posedge clk) disable iff (!reset_n) // see R9
      $rose(flags[21]) |-> ($past(xfer_channel_zero) && !$past(xfer_channel_zero, 2)))
      else $error("transfer channel flag set without a rising edge");

   tie_natural_a: assert property (@(posedge clk) disable iff (!reset_n) // see R10
      (flags[0] && flags[1] && q.en[7] && q.en[8] && q.pa[4:2] != 3'h0
         && $stable(q.pa) && $stable(q.en) && $stable(flags[1:0]) && flags == 25'h3)
         |=> (vec_irq_o == 6'h27))
      else $error("tie not resolved to the lower request");

   irq_level_a: assert property (@(posedge clk) disable iff (!reset_n)
      (|(flags & q.en[31:7])) |=> irq_o)
      else $error("interrupt output low with an enabled flag");

   // ----------------------------------------------------------------
   // Assertions: further slots, persistent set, refusals, enable write and idle levels
   // ----------------------------------------------------------------
   port_chg_vec_a: assert property (@(posedge clk) disable iff (!reset_n) // see R3
      (vec_req_o && vec_irq_o == 6'h2e) |-> vec_num_o == 6'h22)
      else $error("request 46 did not map to vector 34");

   pp_err_vec_a: assert property (@(posedge clk) disable iff (!reset_n) // see R4
      (vec_req_o && vec_irq_o == 6'h31) |-> vec_num_o == 6'h23)
      else $error("request 49 did not map to vector 35");

   uart_two_vec_a: assert property (@(posedge clk) disable iff (!reset_n) // see R6
      (vec_req_o && vec_irq_o == 6'h36) |-> vec_num_o == 6'h25)
      else $error("request 54 did not map to vector 37");

   twi_two_vec_a: assert property (@(posedge clk) disable iff (!reset_n) // see R7
      (vec_req_o && vec_irq_o == 6'h39) |-> vec_num_o == 6'h26)
      else $error("request 57 did not map to vector 38");

   xfer_zero_vec_a: assert property (@(posedge clk) disable iff (!reset_n) // see R8
      (vec_req_o && vec_irq_o == 6'h3c) |-> vec_num_o == 6'h28)
      else $error("request 60 did not map to vector 40");

   persist_set_a: assert property (@(posedge clk) disable iff (!reset_n) // see R9
      (src_evt[20:0] != 21'h0)
         |=> ((flags[20:0] & $past(src_evt[20:0])) == $past(src_evt[20:0])))
      else $error("active persistent source left its flag clear");

   xfer_no_repeat_a: assert property (@(posedge clk) disable iff (!reset_n) // see R9
      (wr_xfer_clr_s and (xfer_channel_three && $past(xfer_channel_three))) |=> !flags[24])
      else $error("held transfer channel flag set again after clear");

   vec_prio_nz_a: assert property (@(posedge clk) disable iff (!reset_n) // see R10
      vec_req_o |-> vec_prio_o != 3'h0)
      else $error("source with priority zero won arbitration");

   vec_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
      !vec_req_o |-> (vec_irq_o == 6'h00 && vec_num_o == 6'h00 && vec_prio_o == 3'h0))
      else $error("vector outputs not zero without a request");

   irq_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
      !(|(flags & q.en[31:7])) |=> !irq_o)
      else $error("interrupt output high with no enabled flag");

   en_write_a: assert property (@(posedge clk) disable iff (!reset_n)
      wr_en_s |=> q.en == ($past(wb_dat_i) & ivm_pkg::FLAG_MASK))
      else $error("enable write did not land masked");

   rdat_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
      !wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside an acknowledge");

endmodule : ivm_irq_vector_map_upper
`default_nettype wire

/* File: bench/ivm_src_model.sv */
// Behavioural peripherals that feed the upper interrupt map.
// Assumes the bench drives the condition vector by non-blocking assignment.
`timescale 1ns/1ns
`default_nettype none

module ivm_src_model (
   // Request conditions, bit 0 is request 39
   input wire logic [24:0] cond,
   // Source lines
   output logic uart_one_fault, uart_one_receive_done, uart_one_transmit_done,
   output logic twi_one_collision, twi_one_slave_event, twi_one_master_event,
   output logic port_a_input_change, port_b_input_change, port_c_input_change,
   output logic parallel_port_event, parallel_port_error,
   output logic spi_two_fault, spi_two_receive_done, spi_two_transfer_done,
   output logic uart_two_error, uart_two_receiver, uart_two_transmitter,
   output logic twi_two_collision, twi_two_slave_event, twi_two_master_event,
   output logic charge_meas_event,
   output logic xfer_channel_zero, xfer_channel_one, xfer_channel_two, xfer_channel_three
);
   // A peripheral keeps its line up until its condition is serviced, so a
   // cleared persistent flag can come straight back
   assign {xfer_channel_three, xfer_channel_two, xfer_channel_one, xfer_channel_zero,
           charge_meas_event, twi_two_master_event, twi_two_slave_event, twi_two_collision,
           uart_two_transmitter, uart_two_receiver, uart_two_error, spi_two_transfer_done,
           spi_two_receive_done, spi_two_fault, parallel_port_error, parallel_port_event,
           port_c_input_change, port_b_input_change, port_a_input_change,
           twi_one_master_event, twi_one_slave_event, twi_one_collision,
           uart_one_transmit_done, uart_one_receive_done, uart_one_fault} = cond;
endmodule : ivm_src_model

`default_nettype wire

/* File: bench/tb_top.sv */
// Self-checking bench for the upper interrupt map over classic Wishbone.
// Assumes one 100 MHz clock and registered outputs of the design.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
   logic clk, reset_n, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, d;
   logic [24:0] cond;
   logic uart_one_fault, uart_one_receive_done, uart_one_transmit_done;
   logic twi_one_collision, twi_one_slave_event, twi_one_master_event;
   logic port_a_input_change, port_b_input_change, port_c_input_change;
   logic parallel_port_event, parallel_port_error, charge_meas_event;
   logic spi_two_fault, spi_two_receive_done, spi_two_transfer_done;
   logic uart_two_error, uart_two_receiver, uart_two_transmitter;
   logic twi_two_collision, twi_two_slave_event, twi_two_master_event;
   logic xfer_channel_zero, xfer_channel_one, xfer_channel_two, xfer_channel_three;
   logic irq_o, vec_req_o;
   logic [5:0] vec_irq_o, vec_num_o;
   logic [2:0] vec_prio_o;
   logic [1:0] vec_sub_o;
   int mismatches, total_checks, cycles;

   ivm_src_model i_src (.*);
   ivm_irq_vector_map_upper i_dut (.*);

   // ----------------------------------------------------------------
   // Clock, timeout and closing
   // ----------------------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // A hung handshake would otherwise never reach the verdict
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : stop_test

   // ----------------------------------------------------------------
   // Bus cycles and comparison
   // ----------------------------------------------------------------
   task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd);
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_sel_i <= 4'hf;
      wb_adr_i <= adr;
      wb_dat_i <= wd;
      do @(posedge clk); while (wb_ack_o !== 1'b1);
      d = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb_xfer

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk

   task automatic pulse(input logic [24:0] v);
      cond <= v;
      @(posedge clk);
      cond <= 25'h000_0000;
      repeat (3) @(posedge clk);
   endtask : pulse

   // Shared vectors: three sources each, the parallel port two, the charge unit and channels their own
   function automatic logic [31:0] vec_of(input int k);
      if (k < 9) return 32'(32 + k / 3);
      if (k < 11) return 32'h23;
      if (k < 20) return 32'(36 + (k - 11) / 3);
      return 32'(19 + k);
   endfunction : vec_of

   // ----------------------------------------------------------------
   // Tests
   // ----------------------------------------------------------------
   initial begin
      reset_n = 1'b0;
      {wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hf;
      wb_dat_i = 32'h0000_0000;
      cond = 25'h000_0000;
      repeat (5) @(posedge clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 6; i++) begin
         wb_xfer(1'b0, 8'(4 * i), 32'h0);
         chk("reset value", 32'h0000_0000, d);
      end
      wb_xfer(1'b1, 8'h04, 32'hffff_ffff);
      wb_xfer(1'b0, 8'h04, 32'h0);
      chk("enable", 32'hffff_ff80, d);
      for (int i = 2; i < 5; i++) begin
         wb_xfer(1'b1, 8'(4 * i), 32'hffff_ffff);
         wb_xfer(1'b0, 8'(4 * i), 32'h0);
         chk("priority", 32'h1f1f_1f1f, d);
         wb_xfer(1'b1, 8'(4 * i), 32'h0404_0404);
      end
      // Every source alone: its flag bit, request number and vector
      for (int k = 0; k < 25; k++) begin
         pulse(25'(1 << k));
         chk("irq", 32'h1, 32'(irq_o));
         chk("vec req", 32'h1, 32'(vec_req_o));
         chk("vec irq", 32'(39 + k), 32'(vec_irq_o));
         chk("vec num", vec_of(k), 32'(vec_num_o));
         wb_xfer(1'b0, 8'h00, 32'h0);
         chk("flag", 32'(1) << (k + 7), d);
         wb_xfer(1'b1, 8'h00, 32'(1) << (k + 7));
      end
      // Two sources sharing one slot: the lower request wins
      pulse(25'h000_0003);
      chk("tie pair", 32'd39, 32'(vec_irq_o));
      wb_xfer(1'b1, 8'h00, 32'h0000_0180);
      // Equal priority ties go by natural order, request 63 last
      pulse(25'h180_0000);
      chk("tie", 32'd62, 32'(vec_irq_o));
      pulse(25'h100_0001);
      chk("tie low", 32'd39, 32'(vec_irq_o));
      wb_xfer(1'b1, 8'h10, 32'h1f04_0404);
      repeat (2) @(posedge clk);
      chk("prio win", 32'd63, 32'(vec_irq_o));
      chk("prio val", 32'h7, 32'(vec_prio_o));
      chk("sub val", 32'h3, 32'(vec_sub_o));
      wb_xfer(1'b1, 8'h00, 32'hffff_ffff);
      // Held conditions: persistent flag returns, channel flag does not
      cond <= 25'h100_0001;
      repeat (2) @(posedge clk);
      wb_xfer(1'b1, 8'h00, 32'h8000_0080);
      repeat (2) @(posedge clk);
      wb_xfer(1'b0, 8'h00, 32'h0);
      chk("persist", 32'h0000_0080, d);
      cond <= 25'h000_0000;
      wb_xfer(1'b1, 8'h00, 32'h0000_0080);
      wb_xfer(1'b0, 8'h00, 32'h0);
      chk("cleared", 32'h0, d);
      // Masking of the parallel port event
      wb_xfer(1'b1, 8'h04, 32'h0);
      pulse(25'h000_0200);
      chk("masked irq", 32'h0, 32'(irq_o));
      chk("masked req", 32'h0, 32'(vec_req_o));
      wb_xfer(1'b1, 8'h04, 32'h0001_0000);
      repeat (2) @(posedge clk);
      chk("unmasked irq", 32'h1, 32'(irq_o));
      chk("pp vector", 32'h23, 32'(vec_num_o));
      wb_xfer(1'b1, 8'h00, 32'h0001_0000);
      repeat (2) @(posedge clk);
      chk("irq cleared", 32'h0, 32'(irq_o));
      // Priority zero keeps the source out of arbitration but not off the level
      wb_xfer(1'b1, 8'h08, 32'h0000_0404);
      pulse(25'h000_0200);
      chk("prio zero irq", 32'h1, 32'(irq_o));
      chk("prio zero req", 32'h0, 32'(vec_req_o));
      stop_test();
   end
endmodule : tb_top

`default_nettype wire
